// [sim/pms_eeprom_model.sv]
// Purpose: Stand-in for the optional configuration EEPROM loader
// Assumes: Load request is a level held until done
// Notes:   Finishes a load DLY+1 cycles after the request
`timescale 1ns/1ns
`default_nettype none

module pms_eeprom_model #(
  parameter int DLY = 6
) (
  input  wire logic mclk_i,
  input  wire logic fitted_i,
  output logic      present_o,
  input  wire logic req_i,
  output var logic  done_o
);
  int cnt = 0;
  initial done_o = 1'b0;
  // Presence follows whether a part is fitted
  assign present_o = fitted_i;
  // Report load done some cycles into a request, hold while asked
  always @(posedge mclk_i) begin
    cnt <= req_i ? cnt + 1 : 0;
    done_o <= req_i && cnt >= DLY;
  end
endmodule
`default_nettype wire

// [sim/pms_mode_select_asserts.sv]
// Purpose: Port checks on the port-zero mode and management selector
// Assumes: Single clock domain, synchronous active-low reset
// Notes:   Bound into pms_mode_select below
`timescale 1ns/1ns
`default_nettype none

module pms_mode_select_asserts
  import pms_pkg::*;
(
  input wire logic       mclk_i,
  input wire logic       reset_n_i,
  input wire logic       eeprom_load_done_i,
  input wire logic       modes_valid_o,
  input wire logic       p0_mac_mode_o,
  input wire logic       p0_phy_mode_o,
  input wire logic       p0_rmii_o,
  input wire logic [2:0] p0_rate_mask_o,
  input wire logic [2:0] p12_rate_mask_o,
  input wire logic       i2c_mgmt_o,
  input wire logic       serial_mgmt_o,
  input wire logic       i2c_slave_en_o,
  input wire logic       i2c_pin_owner_o,
  input wire logic [1:0] smgmt_role_o,
  input wire logic       eeprom_load_req_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  // Mode, rate, role and EEPROM load relations once modes are fixed
  mac_phy_split_a: assert property (modes_valid_o |->
    p0_mac_mode_o != p0_phy_mode_o) else $error("port zero mode clash");
  rmii_no_turbo_a: assert property (p0_rmii_o |->
    p0_phy_mode_o && p0_rate_mask_o == 3'h3) else $error("rmii rate");
  mac_rates_a: assert property (modes_valid_o && p0_mac_mode_o |->
    p0_rate_mask_o == 3'h7) else $error("mac rate mask");
  p12_rates_a: assert property (modes_valid_o |->
    p12_rate_mask_o == 3'h3) else $error("port 1/2 rate mask");
  mgmt_one_hot_a: assert property (modes_valid_o |->
    i2c_mgmt_o != serial_mgmt_o) else $error("management mode clash");
  mgmt_master_a: assert property (modes_valid_o && i2c_mgmt_o &&
    p0_mac_mode_o |-> smgmt_role_o == PMS_SM_MASTER) else $error("no master");
  vphy_slave_a: assert property (modes_valid_o && i2c_mgmt_o &&
    p0_phy_mode_o |-> smgmt_role_o == PMS_SM_SLAVE_VPHY) else $error("vphy");
  modes_frozen_a: assert property (modes_valid_o |=> modes_valid_o &&
    $stable(p0_mac_mode_o) && $stable(smgmt_role_o)) else $error("modes moved");
  load_release_a: assert property (eeprom_load_req_o &&
    eeprom_load_done_i |=> !eeprom_load_req_o) else $error("load req held");
  pin_owner_a: assert property (modes_valid_o |->
    i2c_pin_owner_o == eeprom_load_req_o) else $error("pin owner");
  i2c_slave_a: assert property (modes_valid_o |->
    i2c_slave_en_o == i2c_mgmt_o) else $error("i2c slave enable");

  // Main scenarios reached
  cover property (modes_valid_o && p0_rmii_o);
  cover property (modes_valid_o && smgmt_role_o == PMS_SM_MASTER);
  cover property (modes_valid_o && smgmt_role_o == PMS_SM_SLAVE_VPHY);
  cover property (eeprom_load_req_o && eeprom_load_done_i);
endmodule

bind pms_mode_select pms_mode_select_asserts pms_mode_select_asserts_i (
  .mclk_i, .reset_n_i, .eeprom_load_done_i, .modes_valid_o, .p0_mac_mode_o,
  .p0_phy_mode_o, .p0_rmii_o, .p0_rate_mask_o, .p12_rate_mask_o, .i2c_mgmt_o,
  .serial_mgmt_o, .i2c_slave_en_o, .i2c_pin_owner_o, .smgmt_role_o,
  .eeprom_load_req_o);
`default_nettype wire

// [sim/pms_mode_select_tb.sv]
// Purpose: Self-checking bench for the mode and management selector
// Assumes: Settle count shortened to 2 cycles
// Notes:   Every strap code and pair is swept
`timescale 1ns/1ns
`default_nettype none

module pms_mode_select_tb;
  import pms_pkg::*;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [2:0] port_zero_mode_strap_i = 3'h0;
  logic mgmt_strap_hi_i = 1'b0;
  logic mgmt_strap_lo_i = 1'b0;
  logic fit = 1'b0;
  logic eeprom_present_i, eeprom_load_done_i, modes_valid_o, p0_mac_mode_o;
  logic p0_phy_mode_o, p0_rmii_o, p12_internal_phy_o, i2c_mgmt_o;
  logic serial_mgmt_o, i2c_slave_en_o, i2c_pin_owner_o, eeprom_load_req_o;
  logic smgmt_ext_map_en_o, smgmt_int_phy_en_o, smgmt_vphy_en_o, vphy_en_o;
  logic strap_fault_o;
  logic [2:0] p0_rate_mask_o, p12_rate_mask_o;
  logic [1:0] smgmt_role_o;
  int fail_count = 0;
  int n_checks = 0;

  // Clock generation
  always #50 mclk_i = ~mclk_i;

  pms_mode_select #(.SETTLE_CYCLES(2)) pms_mode_select_i (.mclk_i,
    .reset_n_i, .port_zero_mode_strap_i, .mgmt_strap_hi_i, .mgmt_strap_lo_i,
    .eeprom_present_i, .eeprom_load_done_i, .modes_valid_o, .p0_mac_mode_o,
    .p0_phy_mode_o, .p0_rmii_o, .p0_rate_mask_o, .p12_rate_mask_o,
    .p12_internal_phy_o, .i2c_mgmt_o, .serial_mgmt_o, .i2c_slave_en_o,
    .i2c_pin_owner_o, .eeprom_load_req_o, .smgmt_role_o, .smgmt_ext_map_en_o,
    .smgmt_int_phy_en_o, .smgmt_vphy_en_o, .vphy_en_o, .strap_fault_o);
  pms_eeprom_model pms_eeprom_model_i (.mclk_i, .fitted_i(fit),
    .present_o(eeprom_present_i), .req_i(eeprom_load_req_o),
    .done_o(eeprom_load_done_i));

  task automatic chk(input logic [2:0] s, input logic [2:0] e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h want %h", $time, s, e);
    end
  endtask

  // Reset, apply straps, wait for fixed modes and judge every output
  task automatic run(input logic [2:0] s, input logic [1:0] p, input logic f);
    logic m, i;
    int k;
    @(negedge mclk_i);
    reset_n_i = 1'b0;
    port_zero_mode_strap_i = s;
    {mgmt_strap_hi_i, mgmt_strap_lo_i} = p;
    fit = f;
    @(negedge mclk_i);
    reset_n_i = 1'b1;
    chk(modes_valid_o, 1'b0);
    chk(eeprom_load_req_o, 1'b0);
    k = 0;
    while (modes_valid_o !== 1'b1 && k < 20) begin
      @(negedge mclk_i);
      k++;
    end
    m = (s == 3'h0 || s == 3'h7);
    i = (p == 2'h2);
    chk(k < 20, 1'b1);
    chk(p0_mac_mode_o, m);
    chk(p0_phy_mode_o, !m);
    chk(p0_rmii_o, s == 3'h6);
    chk(p0_rate_mask_o, (s == 3'h6) ? 3'h3 : 3'h7);
    chk(p12_rate_mask_o, 3'h3);
    chk(p12_internal_phy_o, 1'b1);
    chk(i2c_mgmt_o, i);
    chk(serial_mgmt_o, !i);
    chk(i2c_slave_en_o, i);
    chk(smgmt_role_o, !i ? PMS_SM_SLAVE_EXT :
        (m ? PMS_SM_MASTER : PMS_SM_SLAVE_VPHY));
    chk(smgmt_ext_map_en_o, !i);
    chk(smgmt_int_phy_en_o, !i);
    chk(smgmt_vphy_en_o, !m);
    chk(vphy_en_o, !m);
    chk(strap_fault_o, s == 3'h7 || p == 2'h0 || p == 2'h3);
    chk(eeprom_load_req_o, f);
    chk(i2c_pin_owner_o, f);
  endtask

  task automatic sweep_modes;
    for (int s = 0; s < 8; s++)
      for (int p = 0; p < 4; p++)
        run(s[2:0], p[1:0], 1'b0);
  endtask

  task automatic eeprom_load;
    int k;
    run(3'h1, 2'h2, 1'b1);
    k = 0;
    while (eeprom_load_req_o !== 1'b0 && k < 30) begin
      @(negedge mclk_i);
      k++;
    end
    chk(k < 30, 1'b1);
    chk(i2c_pin_owner_o, 1'b0);
    chk(i2c_slave_en_o, 1'b1);
  endtask

  task automatic straps_frozen;
    run(3'h0, 2'h2, 1'b0);
    port_zero_mode_strap_i = 3'h6;
    {mgmt_strap_hi_i, mgmt_strap_lo_i} = 2'h1;
    repeat (6) @(negedge mclk_i);
    chk(p0_mac_mode_o, 1'b1);
    chk(i2c_mgmt_o, 1'b1);
    chk(smgmt_role_o, PMS_SM_MASTER);
  endtask

  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (16) @(negedge mclk_i);
    sweep_modes();
    eeprom_load();
    straps_frozen();
    give_verdict();
  end

  // Watchdog, far beyond the few hundred cycles needed
  initial begin
    #300000;
    fail_count++;
    give_verdict();
  end
endmodule
`default_nettype wire

// [src/pms_consts.svh]
// Purpose: Constants for the port-zero mode and management selector
// Assumes: Included by bare name from the package and pms_mode_select
// Notes:   Strap codes, mode field values and startup timing
`ifndef PMS_CONSTS_SVH
`define PMS_CONSTS_SVH

`define PMS_P0_MAC_CODE     3'h0
`define PMS_P0_BAD_CODE     3'h7
`define PMS_MG_SERIAL_CODE  2'h1
`define PMS_MG_I2C_CODE     2'h2
`define PMS_SETTLE_NS       1000
`define PMS_CLK_PERIOD_NS   100
`define PMS_SETTLE_CYCLES   \
  ((`PMS_SETTLE_NS + `PMS_CLK_PERIOD_NS - 1) / `PMS_CLK_PERIOD_NS)
`define PMS_STRAP_W         5
`define PMS_P0_FIELD        4:2
`define PMS_MG_FIELD        1:0
`define PMS_RATE_10         3'h1
`define PMS_RATE_100        3'h2
`define PMS_RATE_200        3'h4
`define PMS_RMII_CODE       3'h6
`define PMS_I2C_PIN_MASTER  1'h1
`define PMS_I2C_PIN_SLAVE   1'h0

`endif

// [src/pms_mode_select.sv]
// Purpose: Decode startup straps into port-zero and management modes
// Assumes: Straps settle within the settle time after reset release
// Notes:   Unsupported strap codes fall back to MAC mode, serial managed
`timescale 1ns/1ns
`default_nettype none
`include "pms_consts.svh"

module pms_mode_select
  import pms_pkg::*;
#(
  parameter int SETTLE_CYCLES = `PMS_SETTLE_CYCLES
) (
  input  wire logic       mclk_i,
  input  wire logic       reset_n_i,
  input  wire logic [2:0] port_zero_mode_strap_i,
  input  wire logic       mgmt_strap_hi_i,
  input  wire logic       mgmt_strap_lo_i,
  input  wire logic       eeprom_present_i,
  input  wire logic       eeprom_load_done_i,
  output logic            modes_valid_o,
  output logic            p0_mac_mode_o,
  output logic            p0_phy_mode_o,
  output logic            p0_rmii_o,
  output logic [2:0]      p0_rate_mask_o,
  output logic [2:0]      p12_rate_mask_o,
  output logic            p12_internal_phy_o,
  output logic            i2c_mgmt_o,
  output logic            serial_mgmt_o,
  output logic            i2c_slave_en_o,
  output logic            i2c_pin_owner_o,
  output logic            eeprom_load_req_o,
  output logic [1:0]      smgmt_role_o,
  output logic            smgmt_ext_map_en_o,
  output logic            smgmt_int_phy_en_o,
  output logic            smgmt_vphy_en_o,
  output logic            vphy_en_o,
  output logic            strap_fault_o
);

  localparam int CW = $clog2(SETTLE_CYCLES + 1);

  typedef struct packed {
    pms_state_t  state;
    logic [CW-1:0] cnt;
    logic        valid;
    logic        mac;
    logic        phy;
    logic        rmii;
    logic [2:0]  p0_rate;
    logic [2:0]  p12_rate;
    logic        p12_int;
    logic        i2c_m;
    logic        ser_m;
    logic        i2c_slv;
    logic        i2c_own;
    logic        ee_req;
    pms_smgmt_t  role;
    logic        ext_map;
    logic        int_phy;
    logic        vphy_acc;
    logic        vphy;
    logic        fault;
  } pms_sel_t;

  pms_sel_t st_ff;
  pms_sel_t nxt_st;

  logic                    latch_load;
  logic [`PMS_STRAP_W-1:0] latched;
  logic                    latched_vld;

  // Port-zero strap code decodes to MAC mode
  function automatic logic is_mac(input logic [2:0] code);
    return (code == `PMS_P0_MAC_CODE) || (code == `PMS_P0_BAD_CODE);
  endfunction

  // Management pair decodes to I2C managed
  function automatic logic is_i2c(input logic [1:0] pair);
    return pair == `PMS_MG_I2C_CODE;
  endfunction

  assign latch_load = (st_ff.state == PMS_ST_SETTLE) &&
                      (st_ff.cnt == CW'(SETTLE_CYCLES - 1));

  // Strap capture at end of settle window
  pms_strap_latch #(
    .WIDTH (`PMS_STRAP_W)
  ) u_latch (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .load_i    (latch_load),
    .strap_i   ({port_zero_mode_strap_i, mgmt_strap_hi_i,
                 mgmt_strap_lo_i}),
    .strap_o   (latched),
    .valid_o   (latched_vld)
  );

  // Sequencer and mode decode
  always_comb begin
    logic [2:0] p0;
    logic [1:0] mg;
    logic       mac;
    logic       i2c;
    logic       bad;
    p0     = latched[`PMS_P0_FIELD];
    mg     = latched[`PMS_MG_FIELD];
    mac    = is_mac(p0);
    i2c    = is_i2c(mg);
    bad    = (p0 == `PMS_P0_BAD_CODE) ||
             ((mg != `PMS_MG_SERIAL_CODE) && !i2c);
    nxt_st = st_ff;
    case (st_ff.state)
      PMS_ST_SETTLE: begin
        if (latch_load) begin
          nxt_st.state = PMS_ST_LOAD;
        end else begin
          nxt_st.cnt = st_ff.cnt + CW'(1);
        end
      end
      PMS_ST_LOAD: begin
        // Modes frozen from latched straps
        nxt_st.valid    = latched_vld;
        nxt_st.fault    = bad;
        nxt_st.mac      = mac;
        nxt_st.phy      = !mac;
        nxt_st.rmii     = !mac && (p0 == `PMS_RMII_CODE);
        nxt_st.p12_int  = 1'b1;
        nxt_st.p12_rate = `PMS_RATE_10 | `PMS_RATE_100;
        if (!mac && (p0 == `PMS_RMII_CODE)) begin
          nxt_st.p0_rate = `PMS_RATE_10 | `PMS_RATE_100;
        end else begin
          nxt_st.p0_rate = `PMS_RATE_10 | `PMS_RATE_100 |
                           `PMS_RATE_200;
        end
        nxt_st.i2c_m   = i2c;
        nxt_st.ser_m   = !i2c;
        nxt_st.i2c_slv = i2c;
        nxt_st.vphy    = !mac;
        if (i2c && mac) begin
          nxt_st.role     = PMS_SM_MASTER;
          nxt_st.ext_map  = 1'b0;
          nxt_st.int_phy  = 1'b0;
          nxt_st.vphy_acc = 1'b0;
        end else if (i2c) begin
          nxt_st.role     = PMS_SM_SLAVE_VPHY;
          nxt_st.ext_map  = 1'b0;
          nxt_st.int_phy  = 1'b0;
          nxt_st.vphy_acc = 1'b1;
        end else begin
          nxt_st.role     = PMS_SM_SLAVE_EXT;
          nxt_st.ext_map  = 1'b1;
          nxt_st.int_phy  = 1'b1;
          nxt_st.vphy_acc = !mac;
        end
        // Shared I2C pins start as EEPROM master when one is fitted
        nxt_st.ee_req  = eeprom_present_i;
        nxt_st.i2c_own = eeprom_present_i ? `PMS_I2C_PIN_MASTER :
                                            `PMS_I2C_PIN_SLAVE;
        nxt_st.state   = PMS_ST_RUN;
      end
      PMS_ST_RUN: begin
        // Hand pins to the slave once the load completes
        if (st_ff.ee_req && eeprom_load_done_i) begin
          nxt_st.ee_req  = 1'b0;
          nxt_st.i2c_own = `PMS_I2C_PIN_SLAVE;
        end
      end
      default: begin
        nxt_st = '0;
        nxt_st.state = PMS_ST_SETTLE;
      end
    endcase
  end

  // State register, synchronous reset
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      st_ff       <= '0;
      st_ff.state <= PMS_ST_SETTLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign modes_valid_o      = st_ff.valid;
  assign p0_mac_mode_o      = st_ff.mac;
  assign p0_phy_mode_o      = st_ff.phy;
  assign p0_rmii_o          = st_ff.rmii;
  assign p0_rate_mask_o     = st_ff.p0_rate;
  assign p12_rate_mask_o    = st_ff.p12_rate;
  assign p12_internal_phy_o = st_ff.p12_int;
  assign i2c_mgmt_o         = st_ff.i2c_m;
  assign serial_mgmt_o      = st_ff.ser_m;
  assign i2c_slave_en_o     = st_ff.i2c_slv;
  assign i2c_pin_owner_o    = st_ff.i2c_own;
  assign eeprom_load_req_o  = st_ff.ee_req;
  assign smgmt_role_o       = st_ff.role;
  assign smgmt_ext_map_en_o = st_ff.ext_map;
  assign smgmt_int_phy_en_o = st_ff.int_phy;
  assign smgmt_vphy_en_o    = st_ff.vphy_acc;
  assign vphy_en_o          = st_ff.vphy;
  assign strap_fault_o      = st_ff.fault;

endmodule

`default_nettype wire

// [src/pms_pkg.sv]
// Purpose: Types for the port-zero mode and management selector
// Assumes: pms_consts.svh provides the numeric constants
// Notes:   State enum uses one-hot codes
`default_nettype none
`include "pms_consts.svh"

package pms_pkg;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    PMS_ST_SETTLE = 3'h1,
    PMS_ST_LOAD   = 3'h2,
    PMS_ST_RUN    = 3'h4
  } pms_state_t;

  // Management path selection on the serial management pins
  typedef enum logic [1:0] {
    PMS_SM_SLAVE_EXT  = 2'h0,
    PMS_SM_MASTER     = 2'h1,
    PMS_SM_SLAVE_VPHY = 2'h2
  } pms_smgmt_t;

endpackage

`default_nettype wire

// [src/pms_strap_latch.sv]
// Purpose: Capture strap levels once, on a single load pulse
// Assumes: Straps are stable while the load pulse is high
// Notes:   Holds captured values until next reset
`timescale 1ns/1ns
`default_nettype none

module pms_strap_latch
  import pms_pkg::*;
#(
  parameter int WIDTH = 5
) (
  input  wire logic             mclk_i,
  input  wire logic             reset_n_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] strap_i,
  output logic      [WIDTH-1:0] strap_o,
  output logic                  valid_o
);

  typedef struct packed {
    logic [WIDTH-1:0] val;
    logic             vld;
  } pms_latch_t;

  pms_latch_t st_ff;
  pms_latch_t nxt_st;

  // Take straps once, then freeze
  always_comb begin
    nxt_st = st_ff;
    if (load_i && !st_ff.vld) begin
      nxt_st.val = strap_i;
      nxt_st.vld = 1'b1;
    end
  end

  // State register, synchronous reset
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign strap_o = st_ff.val;
  assign valid_o = st_ff.vld;

endmodule

`default_nettype wire
